// >>> osrs_pkg.sv
// Shared constants and types for the OTP space and register shadowing block
package osrs_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] read_identification_cmd = 8'h9f;
  localparam logic [7:0] read_discoverable_params_cmd = 8'h5a;
  localparam logic [7:0] otp_read_cmd = 8'h4b;
  localparam logic [7:0] otp_program_cmd = 8'h42;
  localparam logic [7:0] read_any_reg_cmd = 8'h65;
  localparam logic [7:0] write_any_reg_cmd = 8'h71;
  localparam logic [7:0] read_status1_cmd = 8'h05;
  localparam logic [7:0] read_config1_cmd = 8'h35;
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] clear_status_cmd = 8'h30;
  localparam logic [7:0] reset_enable_cmd = 8'h66;
  localparam logic [7:0] reset_cmd = 8'h99;

  // ----------------------------------------------------------------
  // Register indexes, low address byte of the register commands
  // ----------------------------------------------------------------
  localparam logic [7:0] reg_status1_nv = 8'h00;
  localparam logic [7:0] reg_config1_nv = 8'h02;
  localparam logic [7:0] reg_config2_nv = 8'h03;
  localparam logic [7:0] reg_status1_v = 8'h80;
  localparam logic [7:0] reg_config1_v = 8'h82;
  localparam logic [7:0] reg_config2_v = 8'h83;

  // ----------------------------------------------------------------
  // Field positions, masks and shipped values
  // ----------------------------------------------------------------
  localparam int status_wel_bit = 1;
  localparam int status_perr_bit = 6;
  localparam int config_freeze_bit = 0;
  localparam logic [7:0] status1_nv_wr_mask = 8'h9c;
  localparam logic [7:0] status1_v_wr_mask = 8'h1c;
  localparam logic [7:0] config1_nv_wr_mask = 8'hfe;
  localparam logic [7:0] config1_otp_mask = 8'h3c;
  localparam logic [7:0] status1_shipped = 8'h00;
  localparam logic [7:0] config1_shipped = 8'h00;
  localparam logic [7:0] config2_shipped = 8'h08;

  // ----------------------------------------------------------------
  // OTP space layout
  // ----------------------------------------------------------------
  localparam int otp_bytes = 1024;
  localparam int otp_random_bytes = 16;
  localparam logic [9:0] otp_lock_base = 10'h010;
  localparam logic [7:0] otp_erased = 8'hff;

  // ----------------------------------------------------------------
  // Read-only images; identity values are arbitrary
  // ----------------------------------------------------------------
  localparam logic [63:0] id_space_image = 64'h0000_0000_5152_1a2b;
  localparam logic [63:0] sfdp_header_image = 64'hff01_0001_5044_4653;

  // ----------------------------------------------------------------
  // Link pins sampled together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
    logic hw_rst_n;
  } osrs_link_t;
  localparam osrs_link_t link_idle = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0, hw_rst_n: 1'b1};

endpackage : osrs_pkg

// >>> osrs_top.sv
// SPI-side command engine with OTP space and register shadowing
`timescale 1ns/100ps
`default_nettype none

// Function
// - Command 9Fh streams the identification space; host writes never reach it.
// - Command 5Ah streams the read-only discoverable-parameter space.
// - Parameter space holds the identification contents as one of its tables.
// - OTP space is 1024 bytes in 32 regions of 32 bytes, each lockable.
// - First 16 bytes hold the factory random number; programming ones changes nothing.
// - Programming a zero into random-number bytes fails and sets program error.
// - Bytes 010 to 013 hold one lock bit per region, locked when zero.
// - A region whose lock bit is programmed refuses all further programming.
// - Bytes 014 to 01F are reserved but the host may program them.
// - Lock, reserved and regions 1 to 31 read FF at delivery.
// - Freeze bit set blocks all OTP programming until the next reset of any kind.
// - Registers are reached only through their own instruction codes.
// - Reading a register pair always returns the volatile copy.
// - Any reset loads each volatile copy from its non-volatile copy.
// - Non-volatile writes reprogram the stored copy, then refresh the volatile copy.
// - OTP register bits program the stored copy and update volatile bits too.
// - Volatile writes change only the volatile copy.
// - Volatile bits take the stored values on reset; stored bits keep their written values.
module osrs_top #(
  parameter logic [127:0] RANDOM_VALUE = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic RESET_N_I,
  output logic SO_O,
  output logic SO_OE_O
);

  typedef enum logic [1:0] {st_cmd, st_hdr, st_data, st_skip} osrs_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] image_byte(input logic [63:0] img, input logic [2:0] idx);
    image_byte = img[{idx, 3'h0} +: 8];
  endfunction : image_byte

  // Address plus dummy bytes that follow each instruction
  function automatic logic [2:0] cmd_hdr_len(input logic [7:0] code);
    case (code)
      osrs_pkg::read_discoverable_params_cmd: cmd_hdr_len = 3'h4;
      osrs_pkg::otp_read_cmd: cmd_hdr_len = 3'h4;
      osrs_pkg::otp_program_cmd: cmd_hdr_len = 3'h3;
      osrs_pkg::read_any_reg_cmd: cmd_hdr_len = 3'h3;
      osrs_pkg::write_any_reg_cmd: cmd_hdr_len = 3'h3;
      default: cmd_hdr_len = 3'h0;
    endcase
  endfunction : cmd_hdr_len

  function automatic logic is_read(input logic [7:0] code);
    is_read = (code == osrs_pkg::read_identification_cmd) ||
              (code == osrs_pkg::read_discoverable_params_cmd) ||
              (code == osrs_pkg::otp_read_cmd) || (code == osrs_pkg::read_any_reg_cmd) ||
              (code == osrs_pkg::read_status1_cmd) || (code == osrs_pkg::read_config1_cmd);
  endfunction : is_read

  // Register pair view; the copy select bit is ignored so reads show the volatile copy
  function automatic logic [7:0] reg_view(input logic [7:0] idx, input logic [7:0] s1,
                                          input logic [7:0] c1, input logic [7:0] c2);
    case (idx[6:0])
      7'h00: reg_view = s1;
      7'h02: reg_view = c1;
      7'h03: reg_view = c2;
      default: reg_view = 8'h00;
    endcase
  endfunction : reg_view

  // ----------------------------------------------------------------
  // Link synchronisers
  // ----------------------------------------------------------------
  osrs_pkg::osrs_link_t link_meta;
  osrs_pkg::osrs_link_t link_s2;
  osrs_pkg::osrs_link_t link_s3;
  osrs_pkg::osrs_link_t link_filt;
  osrs_pkg::osrs_link_t link_prev;
  logic [3:0] next_filt_bits;

  // A pin change is taken only once stages two and three agree
  assign next_filt_bits = (link_s2 & link_s3) | (link_filt & (link_s2 | link_s3));

  // Three stages, then the agreed level and its previous value
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      link_meta <= osrs_pkg::link_idle;
      link_s2 <= osrs_pkg::link_idle;
      link_s3 <= osrs_pkg::link_idle;
      link_filt <= osrs_pkg::link_idle;
      link_prev <= osrs_pkg::link_idle;
    end else begin
      link_meta <= '{sck: SCK_I, cs_n: CS_N_I, mosi: SI_I, hw_rst_n: RESET_N_I};
      link_s2 <= link_meta;
      link_s3 <= link_s2;
      link_filt <= osrs_pkg::osrs_link_t'(next_filt_bits);
      link_prev <= link_filt;
    end
  end

  wire sck_rise = link_filt.sck & ~link_prev.sck;
  wire sck_fall = ~link_filt.sck & link_prev.sck;
  wire cs_end = link_filt.cs_n & ~link_prev.cs_n;
  wire hw_reset = ~link_filt.hw_rst_n;

  // ----------------------------------------------------------------
  // Command engine state
  // ----------------------------------------------------------------
  osrs_state_t state;
  osrs_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] hdr_cnt;
  logic [7:0] rx_sh;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [7:0] tx_sh;
  logic [7:0] otp_mem [0:osrs_pkg::otp_bytes-1];
  logic [7:0] status1_nonvolatile;
  logic [7:0] config1_nonvolatile;
  logic [7:0] config2_nonvolatile;
  logic [7:0] status1_volatile;
  logic [7:0] config1_volatile;
  logic [7:0] config2_volatile;
  logic wr_done;
  logic rst_armed;
  logic [7:0] rd_data;

  // Byte assembly and header tracking
  wire [7:0] rx_byte = {rx_sh[6:0], link_filt.mosi};
  wire byte_now = sck_rise & ~link_filt.cs_n & (bit_cnt == 3'h7);
  wire [2:0] first_len = cmd_hdr_len(rx_byte);
  wire hdr_last = (hdr_cnt + 3'h1) == cmd_hdr_len(cmd);
  wire [23:0] addr_shift = (hdr_cnt < 3'h3) ? {addr[15:0], rx_byte} : addr;
  wire [23:0] addr_inc = addr + 24'h000001;
  wire cmd_stream = is_read(rx_byte);

  assign next_state = (state == st_cmd) ? ((first_len != 3'h0) ? st_hdr :
                                           (cmd_stream ? st_data : st_skip)) :
                      (state == st_hdr) ? (hdr_last ? st_data : st_hdr) : state;
  assign next_addr = (state == st_cmd) ? 24'h000000 :
                     (state == st_hdr) ? addr_shift : addr_inc;

  // Source of the next byte shifted out; computed for the address about to apply
  wire [7:0] rd_cmd = (state == st_cmd) ? rx_byte : cmd;
  wire [2:0] rd_lo = next_addr[2:0];
  assign rd_data =
    (rd_cmd == osrs_pkg::read_identification_cmd) ?
      image_byte(osrs_pkg::id_space_image, rd_lo) :
    (rd_cmd == osrs_pkg::read_discoverable_params_cmd) ? (next_addr[3] ?
      image_byte(osrs_pkg::id_space_image, rd_lo) :
      image_byte(osrs_pkg::sfdp_header_image, rd_lo)) :
    (rd_cmd == osrs_pkg::otp_read_cmd) ? otp_mem[next_addr[9:0]] :
    (rd_cmd == osrs_pkg::read_any_reg_cmd) ? reg_view(next_addr[7:0], status1_volatile, config1_volatile, config2_volatile) :
    (rd_cmd == osrs_pkg::read_status1_cmd) ? status1_volatile :
    (rd_cmd == osrs_pkg::read_config1_cmd) ? config1_volatile : 8'h00;

  // Shift engine; a deselect or reset pin always returns it to the opcode
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state <= st_cmd;
      bit_cnt <= 3'h0;
      hdr_cnt <= 3'h0;
      rx_sh <= 8'h00;
      cmd <= 8'h00;
      addr <= 24'h000000;
      tx_sh <= 8'h00;
    end else if (link_filt.cs_n || hw_reset) begin
      state <= st_cmd;
      bit_cnt <= 3'h0;
      hdr_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= rx_byte;
      if (bit_cnt == 3'h7) begin
        state <= next_state;
        addr <= next_addr;
        tx_sh <= rd_data;
        if (state == st_cmd) begin
          cmd <= rx_byte;
        end
        if (state == st_hdr) begin
          hdr_cnt <= hdr_cnt + 3'h1;
        end
      end
    end else if (sck_fall) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // Output pin driven on falling clock edges only while streaming a read
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SO_O <= 1'b0;
      SO_OE_O <= 1'b0;
    end else begin
      SO_OE_O <= ~link_filt.cs_n & (state == st_data) & is_read(cmd);
      if (link_filt.cs_n) begin
        SO_O <= 1'b0;
      end else if (sck_fall) begin
        SO_O <= tx_sh[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // OTP programming checks
  // ----------------------------------------------------------------
  wire wel = status1_volatile[osrs_pkg::status_wel_bit];
  wire freeze = config1_volatile[osrs_pkg::config_freeze_bit];
  wire [9:0] pa = addr[9:0];
  wire [9:0] lock_addr = osrs_pkg::otp_lock_base + {7'h00, pa[9:8]};
  wire [7:0] lock_byte = otp_mem[lock_addr];
  wire locked = ~lock_byte[pa[7:5]];
  wire in_random = pa < 10'(osrs_pkg::otp_random_bytes);
  wire [7:0] prog_cell = otp_mem[pa];
  // Without the write enable latch the command is simply ignored
  wire prog_fire = byte_now & (state == st_data) & (cmd == osrs_pkg::otp_program_cmd) & wel;
  wire prog_ok = prog_fire & ~freeze & ~locked & ~in_random;
  wire prog_bad = prog_fire & (freeze | locked |
                               (in_random & (rx_byte != osrs_pkg::otp_erased)));

  // OTP cells only clear bits; delivery state is FF with the random number below
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < osrs_pkg::otp_bytes; i++) begin
        otp_mem[i] <= (i < osrs_pkg::otp_random_bytes) ? RANDOM_VALUE[i*8 +: 8] :
                      osrs_pkg::otp_erased;
      end
    end else if (prog_ok) begin
      otp_mem[pa] <= prog_cell & rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and shadowing
  // ----------------------------------------------------------------
  wire [7:0] widx = addr[7:0];
  wire reg_wr_fire = byte_now & (state == st_data) &
                     (cmd == osrs_pkg::write_any_reg_cmd) & wel & ~wr_done;
  wire wr_s1nv = reg_wr_fire & (widx == osrs_pkg::reg_status1_nv);
  wire wr_c1nv = reg_wr_fire & (widx == osrs_pkg::reg_config1_nv);
  wire wr_c2nv = reg_wr_fire & (widx == osrs_pkg::reg_config2_nv);
  wire wr_s1v = reg_wr_fire & (widx == osrs_pkg::reg_status1_v);
  wire wr_c1v = reg_wr_fire & (widx == osrs_pkg::reg_config1_v);
  wire wr_c2v = reg_wr_fire & (widx == osrs_pkg::reg_config2_v);
  wire cmd_done = byte_now & (state == st_cmd);
  wire sw_reload = cmd_done & rst_armed & (rx_byte == osrs_pkg::reset_cmd);
  wire reload = sw_reload | hw_reset;
  wire wr_cmd_end = cs_end & ((cmd == osrs_pkg::otp_program_cmd) |
                              (cmd == osrs_pkg::write_any_reg_cmd));
  wire [7:0] next_status1_nonvolatile = (status1_nonvolatile & ~osrs_pkg::status1_nv_wr_mask) |
                          (rx_byte & osrs_pkg::status1_nv_wr_mask);
  // OTP-type bits are set once and then stay set; later writes cannot clear them
  wire [7:0] next_config1_nonvolatile = (rx_byte | (config1_nonvolatile & osrs_pkg::config1_otp_mask)) &
                          osrs_pkg::config1_nv_wr_mask;

  // Stored copies: untouched by any reset but power-up, changed only by writes
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      status1_nonvolatile <= osrs_pkg::status1_shipped;
      config1_nonvolatile <= osrs_pkg::config1_shipped;
      config2_nonvolatile <= osrs_pkg::config2_shipped;
    end else begin
      if (wr_s1nv) begin
        status1_nonvolatile <= next_status1_nonvolatile;
      end
      if (wr_c1nv) begin
        config1_nonvolatile <= next_config1_nonvolatile;
      end
      if (wr_c2nv) begin
        config2_nonvolatile <= rx_byte;
      end
    end
  end

  // Volatile copies; a reset reload outranks any write in the same cycle
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      status1_volatile <= osrs_pkg::status1_shipped;
      config1_volatile <= osrs_pkg::config1_shipped;
      config2_volatile <= osrs_pkg::config2_shipped;
    end else if (reload) begin
      status1_volatile <= status1_nonvolatile;
      config1_volatile <= config1_nonvolatile;
      config2_volatile <= config2_nonvolatile;
    end else begin
      // Refresh after a stored write, or a volatile-only write
      if (wr_s1nv || wr_s1v) begin
        status1_volatile <= (status1_volatile & ~osrs_pkg::status1_v_wr_mask) |
                ((wr_s1nv ? next_status1_nonvolatile : rx_byte) & osrs_pkg::status1_v_wr_mask);
      end
      if (wr_c1nv) begin
        config1_volatile <= {next_config1_nonvolatile[7:1], freeze};
      end
      // Freeze can be set but never cleared short of a reset
      if (wr_c1v) begin
        config1_volatile <= {rx_byte[7:1], freeze | rx_byte[0]};
      end
      if (wr_c2nv || wr_c2v) begin
        config2_volatile <= rx_byte;
      end
      // Write latch: set by enable, cleared by disable or the end of a write
      if (cmd_done && rx_byte == osrs_pkg::write_enable_cmd) begin
        status1_volatile[osrs_pkg::status_wel_bit] <= 1'b1;
      end else if ((cmd_done && rx_byte == osrs_pkg::write_disable_cmd) || wr_cmd_end) begin
        status1_volatile[osrs_pkg::status_wel_bit] <= 1'b0;
      end
      // Error flag: a failing program wins over a clear in the same cycle
      if (prog_bad) begin
        status1_volatile[osrs_pkg::status_perr_bit] <= 1'b1;
      end else if (cmd_done && rx_byte == osrs_pkg::clear_status_cmd) begin
        status1_volatile[osrs_pkg::status_perr_bit] <= 1'b0;
      end
    end
  end

  // Single-byte write per transfer and software-reset arming
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wr_done <= 1'b0;
      rst_armed <= 1'b0;
    end else begin
      if (link_filt.cs_n) begin
        wr_done <= 1'b0;
      end else if (reg_wr_fire) begin
        wr_done <= 1'b1;
      end
      if (cmd_done) begin
        rst_armed <= (rx_byte == osrs_pkg::reset_enable_cmd);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking osrs_cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  a_freeze_blocks_otp: assert property (
    prog_fire && freeze && !reload |=> otp_mem[$past(pa)] == $past(prog_cell) &&
      status1_volatile[osrs_pkg::status_perr_bit])
    else $error("OTP cell changed while frozen");

  a_lock_refuses_prog: assert property (
    prog_fire && locked && !reload |=> otp_mem[$past(pa)] == $past(prog_cell) &&
      status1_volatile[osrs_pkg::status_perr_bit])
    else $error("Locked region accepted programming");

  a_random_zero_err: assert property (
    prog_fire && in_random && rx_byte != osrs_pkg::otp_erased && !reload |=>
      status1_volatile[osrs_pkg::status_perr_bit] && otp_mem[$past(pa)] == $past(prog_cell))
    else $error("Zero into random number not refused");

  a_random_ones_kept: assert property (
    prog_fire && in_random && rx_byte == osrs_pkg::otp_erased && !reload |=>
      otp_mem[$past(pa)] == $past(prog_cell) &&
      status1_volatile[osrs_pkg::status_perr_bit] == $past(status1_volatile[osrs_pkg::status_perr_bit]))
    else $error("Programming ones altered random number");

  a_nv_refresh_v: assert property (
    wr_c2nv && !reload |=> config2_volatile == config2_nonvolatile && config2_nonvolatile == $past(rx_byte))
    else $error("Volatile copy not refreshed after stored write");

  a_vol_write_only: assert property (
    reg_wr_fire && widx[7] |=> $stable(status1_nonvolatile) && $stable(config1_nonvolatile) && $stable(config2_nonvolatile))
    else $error("Volatile write disturbed a stored copy");

  a_otp_bits_track: assert property (
    wr_c1nv && !reload |=> (config1_volatile & osrs_pkg::config1_otp_mask) ==
      (config1_nonvolatile & osrs_pkg::config1_otp_mask))
    else $error("OTP-type bits not mirrored into volatile copy");

  a_reset_reload: assert property (
    reload |=> status1_volatile == $past(status1_nonvolatile) && config1_volatile == $past(config1_nonvolatile) && config2_volatile == $past(config2_nonvolatile))
    else $error("Reset did not load volatile copies");

  a_read_gives_vol: assert property (
    byte_now && state == st_hdr && hdr_last && cmd == osrs_pkg::read_any_reg_cmd &&
      addr_shift[7:0] == osrs_pkg::reg_config2_nv |=> tx_sh == $past(config2_volatile))
    else $error("Register read did not return volatile copy");

  a_id_space_ro: assert property (
    state == st_data && (cmd == osrs_pkg::read_identification_cmd ||
      cmd == osrs_pkg::read_discoverable_params_cmd) |-> !prog_ok && !reg_wr_fire)
    else $error("Read-only space read caused a write");

endmodule : osrs_top

`default_nettype wire

// >>> osrs_host.sv
// SPI host model that frames flash commands on the link pins
`timescale 1ns/100ps
`default_nettype none
module osrs_host (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  // Half of the 48 ns link period, counted in system cycles
  localparam int half_cycles = 6;
  // Link clock rests low between frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // One framed transfer, header bytes first, then read bytes
  // ----------------------------------------------------------------
  // SI toggles while it carries nothing so no stale level looks valid
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                      output logic [63:0] rx);
    rx = '0;
    @(negedge clk_i);
    cs_n_o <= 1'b0;
    for (int b = 0; b < 8 * (ntx + nrx); b++) begin
      si_o <= (b < 8 * ntx) ? tx[63 - b] : ~si_o;
      repeat (half_cycles) @(negedge clk_i);
      if (b >= 8 * ntx) rx = {rx[62:0], so_i};
      sck_o <= 1'b1;
      repeat (half_cycles) @(negedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (half_cycles) @(negedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4 * half_cycles) @(negedge clk_i);
  endtask : xfer
endmodule : osrs_host
`default_nettype wire

// >>> osrs_bench.sv
// Self-checking bench for the OTP space and register shadowing block
`timescale 1ns/100ps
`default_nettype none
module osrs_bench;
  // Random number value is arbitrary
  localparam logic [127:0] rnd = 128'h1827_3645_5463_7281_a9b8_c7d6_e5f4_0312;
  typedef struct {
    logic [63:0] tx;
    int ntx;
    int nrx;
    logic [63:0] exp;
  } osrs_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reset_n = 1'b1;
  logic sck, cs_n, si, so, so_oe;
  logic [63:0] rx;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  // First byte shifted out lands on top
  function automatic logic [63:0] rev8(input logic [63:0] v);
    for (int i = 0; i < 8; i++) rev8[8 * i +: 8] = v[56 - 8 * i +: 8];
  endfunction : rev8
  function automatic logic [63:0] hdr(input logic [7:0] op, input logic [23:0] a);
    return {op, a, 32'h0};
  endfunction : hdr
  // ----------------------------------------------------------------
  // Ordinary reads: request, header length, read length, expected
  // ----------------------------------------------------------------
  osrs_row_t rows [12] = '{
    '{hdr(osrs_pkg::read_identification_cmd, 24'h0), 1, 8, rev8(osrs_pkg::id_space_image)},
    '{hdr(osrs_pkg::read_discoverable_params_cmd, 24'h0), 5, 8,
      rev8(osrs_pkg::sfdp_header_image)},
    '{hdr(osrs_pkg::read_discoverable_params_cmd, 24'h8), 5, 8, rev8(osrs_pkg::id_space_image)},
    '{hdr(osrs_pkg::otp_read_cmd, 24'h0), 5, 8, rev8(rnd[63:0])},
    '{hdr(osrs_pkg::otp_read_cmd, 24'h8), 5, 8, rev8(rnd[127:64])},
    '{hdr(osrs_pkg::otp_read_cmd, 24'h10), 5, 8, {8{8'hff}}},
    '{hdr(osrs_pkg::otp_read_cmd, 24'h18), 5, 8, {8{8'hff}}},
    '{hdr(osrs_pkg::otp_read_cmd, 24'h3f8), 5, 8, {8{8'hff}}},
    '{hdr(osrs_pkg::read_status1_cmd, 24'h0), 1, 1, 64'h0},
    '{hdr(osrs_pkg::read_config1_cmd, 24'h0), 1, 1, {56'h0, osrs_pkg::config1_shipped}},
    '{hdr(osrs_pkg::read_any_reg_cmd, 24'h83), 4, 1, {56'h0, osrs_pkg::config2_shipped}},
    '{hdr(osrs_pkg::read_any_reg_cmd, 24'h3), 4, 1, {56'h0, osrs_pkg::config2_shipped}}
  };
  always #2 clk_sys = ~clk_sys;
  osrs_top #(.RANDOM_VALUE(rnd)) DUT (.CLK_SYS_I(clk_sys), .RST_I(rst), .SCK_I(sck),
    .CS_N_I(cs_n), .SI_I(si), .RESET_N_I(reset_n), .SO_O(so), .SO_OE_O(so_oe));
  osrs_host host (.clk_i(clk_sys), .so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
  // Cuts a hang short; the whole run needs about 33000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      err_total++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic run(input logic [63:0] tx, input int ntx, input int nrx);
    host.xfer(tx, ntx, nrx, rx);
  endtask : run
  // Write enable is dropped at the end of every write, so arm before each write
  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    run(hdr(osrs_pkg::write_enable_cmd, 24'h0), 1, 0);
    run({osrs_pkg::otp_program_cmd, a, d, 24'h0}, 5, 0);
  endtask : prog
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    run(hdr(osrs_pkg::write_enable_cmd, 24'h0), 1, 0);
    run({osrs_pkg::write_any_reg_cmd, 16'h0, idx, d, 24'h0}, 5, 0);
  endtask : wreg
  task automatic rdo(input logic [23:0] a);
    run(hdr(osrs_pkg::otp_read_cmd, a), 5, 1);
  endtask : rdo
  task automatic rreg(input logic [7:0] idx);
    run(hdr(osrs_pkg::read_any_reg_cmd, {16'h0, idx}), 4, 1);
  endtask : rreg
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(negedge clk_sys);
    foreach (rows[i]) begin
      run(rows[i].tx, rows[i].ntx, rows[i].nrx);
      chk("read row", rows[i].exp, rx);
    end
    // Program without write enable, then a real program and an all-ones retry
    run({osrs_pkg::otp_program_cmd, 24'h20, 8'h00, 24'h0}, 5, 0);
    rdo(24'h20);
    chk("unarmed program", 64'hff, rx);
    prog(24'h20, 8'ha5);
    prog(24'h20, 8'hff);
    rdo(24'h20);
    chk("region 1 byte", 64'ha5, rx);
    // Write disable drops the latch, so the program is ignored
    run(hdr(osrs_pkg::write_enable_cmd, 24'h0), 1, 0);
    run(hdr(osrs_pkg::write_disable_cmd, 24'h0), 1, 0);
    run({osrs_pkg::otp_program_cmd, 24'h22, 8'h00, 24'h0}, 5, 0);
    rdo(24'h22);
    chk("disabled program", 64'hff, rx);
    // Random number bytes: ones ignored, zeros refused with error
    prog(24'h0, 8'hff);
    rreg(osrs_pkg::reg_status1_v);
    chk("status after ones", 64'h0, rx);
    prog(24'h0, 8'h00);
    rreg(osrs_pkg::reg_status1_v);
    chk("status after zeros", 64'h40, rx);
    rdo(24'h0);
    chk("random byte", {56'h0, rnd[7:0]}, rx);
    run(hdr(osrs_pkg::clear_status_cmd, 24'h0), 1, 0);
    // Lock region 1, then try to program it
    prog(24'h10, 8'hfd);
    rdo(24'h10);
    chk("lock byte", 64'hfd, rx);
    prog(24'h21, 8'h00);
    rdo(24'h21);
    chk("locked region", 64'hff, rx);
    rreg(osrs_pkg::reg_status1_v);
    chk("locked error", 64'h40, rx);
    run(hdr(osrs_pkg::clear_status_cmd, 24'h0), 1, 0);
    prog(24'h14, 8'h3c);
    rdo(24'h14);
    chk("reserved byte", 64'h3c, rx);
    // Stored and volatile register copies
    wreg(osrs_pkg::reg_config1_nv, 8'h44);
    rreg(osrs_pkg::reg_config1_v);
    chk("config1 refresh", 64'h44, rx);
    wreg(osrs_pkg::reg_config1_nv, 8'h40);
    rreg(osrs_pkg::reg_config1_v);
    chk("config1 otp bit", 64'h44, rx);
    wreg(osrs_pkg::reg_config2_nv, 8'h0b);
    rreg(osrs_pkg::reg_config2_v);
    chk("config2 refresh", 64'h0b, rx);
    wreg(osrs_pkg::reg_status1_v, 8'h08);
    rreg(osrs_pkg::reg_status1_nv);
    chk("status1 pair read", 64'h08, rx);
    reset_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    rreg(osrs_pkg::reg_status1_v);
    chk("status1 reload", 64'h0, rx);
    rreg(osrs_pkg::reg_config1_v);
    chk("config1 kept", 64'h44, rx);
    wreg(osrs_pkg::reg_status1_v, 8'h10);
    run(hdr(osrs_pkg::reset_enable_cmd, 24'h0), 1, 0);
    run(hdr(osrs_pkg::reset_cmd, 24'h0), 1, 0);
    rreg(osrs_pkg::reg_status1_v);
    chk("software reset", 64'h0, rx);
    // Freeze blocks programming in region 2
    wreg(osrs_pkg::reg_config1_v, 8'h41);
    prog(24'h40, 8'h00);
    rdo(24'h40);
    chk("frozen region", 64'hff, rx);
    // Power-up reset restores delivery state
    rst <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("pins in reset", 64'h0, {62'h0, so_oe, so});
    rst <= 1'b0;
    repeat (8) @(negedge clk_sys);
    rdo(24'h20);
    chk("delivery byte", 64'hff, rx);
    final_report();
  end
endmodule : osrs_bench
`default_nettype wire
